// >>> logic/reset_remap_regs.vh
// Register map, reset values and fixed codes of the reset-cause and remap block.
// Assumes a 32-bit classic Wishbone bus with byte addresses and 8-bit registers in lane 0.
`ifndef RESET_REMAP_REGS_VH
`define RESET_REMAP_REGS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADR_MEMORY_MAP_SWAP_CONTROL 32'hffff0220
`define ADR_RESET_CAUSE_STATUS 32'hffff0230
`define ADR_RESET_CAUSE_CLEAR 32'hffff0234
`define ADR_RESET_UNLOCK_KEY_A 32'hffff0248
`define ADR_RESET_RETENTION_CONFIG 32'hffff024c
`define ADR_RESET_UNLOCK_KEY_B 32'hffff0250
`define ADR_EVENT_STATUS 32'hffff0260
`define ADR_EVENT_MASK 32'hffff0264

// ****************************************
// Reset values
// ****************************************
`define RST_MEMORY_MAP_SWAP_CONTROL 8'h00
`define RST_RESET_CAUSE_STATUS 8'h01
`define RST_RESET_RETENTION_CONFIG 8'h05
`define RST_EVENT_STATUS 8'h00
`define RST_EVENT_MASK 8'h00

// ****************************************
// Field positions
// ****************************************
`define BIT_REMAP_SRAM 0
`define BIT_CAUSE_POWER_ON 0
`define BIT_CAUSE_WATCHDOG 1
`define BIT_CAUSE_SOFTWARE 2
`define BIT_KEEP_GPIO 0
`define BIT_KEEP_DAC 2
`define BIT_EVT_CFG_COMMIT 0
`define BIT_EVT_KEY_ERROR 1
`define BIT_EVT_BOOT_DONE 2
`define CAUSE_MASK 8'h07
`define RETENTION_MASK 8'h05
`define EVENT_MASK_BITS 8'h07

// ****************************************
// Key codes and map constants
// ****************************************
`define KEY_A_CODE 8'h76
`define KEY_B_CODE 8'hb1
`define VECTOR_REGION_TOP 32'h00000020
`define USER_RESET_VECTOR 32'h00000000

// ****************************************
// Default sequencing counts
// ****************************************
`define HOLD_CYCLES_DEFAULT 16'h0010
`define KERNEL_CYCLES_DEFAULT 16'h0020

`endif

// >>> logic/level_sync.v
// Two-flop synchroniser for slow levels that arrive from pins.
// Assumes the levels change slower than two clock periods.
`default_nettype none

module level_sync #(
	parameter WIDTH = 2,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Levels
	input wire [WIDTH-1:0] d_i,
	output reg [WIDTH-1:0] q_o
);

	reg [WIDTH-1:0] meta;

	// Only the second stage reads the first one
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta <= INIT;
			q_o <= INIT;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end

endmodule

`default_nettype wire

// >>> logic/reset_cause_and_memory_remap.v
// Reset sequencing, reset-cause record, retention keys and low-memory remap.
// Assumes rst_i is the power-on reset and a classic Wishbone master on clk_i.
//
// Operation
// - Remap bit set selects SRAM for the lowest addresses instead of nonvolatile memory.
// - Every reset kind clears the remap bit.
// - Software clearing the remap bit brings the nonvolatile mirror back.
// - The remapped vector region runs from address zero up to 0x20.
// - Reset starts hidden kernel code, then jumps to user vector when boot pin high.
// - Four reset sources exist; recorded causes stay set for software until written clear.
// - Power-on reset sets cause bit 0.
// - Watchdog timeout reset sets cause bit 1.
// - Writing bit 2 forces a software reset and flags cause bit 2.
// - All cause bits zero means the reset was external.
// - Writing one to a clear bit clears that cause bit; 0x07 clears all.
// - Retention bit 2 keeps DAC state through watchdog or software reset.
// - Retention bit 0 keeps GPIO state through watchdog or software reset.
//
// Chosen here: the Wishbone register port.
`include "reset_remap_regs.vh"
`default_nettype none

module reset_cause_and_memory_remap #(
	parameter [15:0] HOLD_CYCLES = `HOLD_CYCLES_DEFAULT,
	parameter [15:0] KERNEL_CYCLES = `KERNEL_CYCLES_DEFAULT
) (
	// Clock and power-on reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [31:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg ack_o,
	output reg [31:0] dat_o,
	// Reset sources
	input wire ext_rst_n_i,
	input wire wdt_timeout_i,
	// Boot strap pin
	input wire boot_mode_pin_i,
	// Memory map steering
	input wire [31:0] map_adr_i,
	output reg remap_sram_o,
	output reg low_sram_sel_o,
	output reg low_nvm_sel_o,
	// Reset outputs
	output reg sys_rst_o,
	output reg gpio_rst_o,
	output reg dac_rst_o,
	// Boot control
	output reg kernel_active_o,
	output reg user_jump_o,
	output reg [31:0] user_vector_o,
	// Interrupt
	output reg irq_o
);

	// ****************************************
	// State codes
	// ****************************************
	localparam [1:0] SEQ_HOLD = 2'b00;
	localparam [1:0] SEQ_KERNEL = 2'b01;
	localparam [1:0] SEQ_RUN = 2'b10;

	localparam [1:0] KEY_IDLE = 2'b00;
	localparam [1:0] KEY_ARMED = 2'b01;
	localparam [1:0] KEY_HELD = 2'b10;
	localparam [7:0] EVT_RESET = `RST_EVENT_STATUS;
	localparam [7:0] EVT_USED = `EVENT_MASK_BITS;

	// ****************************************
	// Declarations
	// ****************************************
	wire [1:0] pins_sync;
	wire [7:0] wdat;
	wire [7:0] evt_set;
	wire ext_low, boot_high, req, wr, sw_req, any_reset;
	wire hit_remap, hit_status, hit_clear, hit_key_a, hit_cfg, hit_key_b, hit_evt, hit_mask;
	wire key_error, cfg_commit, boot_done;

	reg remap, hard, next_hard;
	reg [7:0] cause, retain, pending, evt, mask, rdat;
	reg [1:0] key_state, next_key_state, seq_state, next_seq_state;
	reg [15:0] count, next_count;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Pins idle high; a low boot pin after reset keeps the kernel in control
	level_sync #(
		.WIDTH(2),
		.INIT(2'b11)
	) pin_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({boot_mode_pin_i, ext_rst_n_i}),
		.q_o(pins_sync)
	);

	assign ext_low = ~pins_sync[0];
	assign boot_high = pins_sync[1];

	// ****************************************
	// Bus decode
	// ****************************************
	// Registers are 8 bits wide in byte lane 0; other lanes are ignored
	assign req = cyc_i & stb_i & ~ack_o;
	assign wr = req & we_i & sel_i[0];
	assign wdat = dat_i[7:0];

	assign hit_remap = (adr_i == `ADR_MEMORY_MAP_SWAP_CONTROL);
	assign hit_status = (adr_i == `ADR_RESET_CAUSE_STATUS);
	assign hit_clear = (adr_i == `ADR_RESET_CAUSE_CLEAR);
	assign hit_key_a = (adr_i == `ADR_RESET_UNLOCK_KEY_A);
	assign hit_cfg = (adr_i == `ADR_RESET_RETENTION_CONFIG);
	assign hit_key_b = (adr_i == `ADR_RESET_UNLOCK_KEY_B);
	assign hit_evt = (adr_i == `ADR_EVENT_STATUS);
	assign hit_mask = (adr_i == `ADR_EVENT_MASK);

	assign sw_req = wr & hit_status & wdat[`BIT_CAUSE_SOFTWARE];
	assign any_reset = ext_low | wdt_timeout_i | sw_req;

	always @* begin
		rdat = 8'h00;
		if (hit_remap) begin
			rdat = {7'h00, remap};
		end else if (hit_status) begin
			rdat = cause;
		end else if (hit_cfg) begin
			rdat = retain;
		end else if (hit_evt) begin
			rdat = evt;
		end else if (hit_mask) begin
			rdat = mask;
		end
	end

	// Every access, mapped or not, is answered one cycle after it starts
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req;
			if (req & ~we_i) begin
				dat_o <= {24'h000000, rdat};
			end
		end
	end

	// ****************************************
	// Remap control
	// ****************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			remap <= `RST_MEMORY_MAP_SWAP_CONTROL == 8'h00 ? 1'b0 : 1'b1;
		end else if (any_reset) begin
			remap <= 1'b0;
		end else if (wr & hit_remap) begin
			remap <= wdat[`BIT_REMAP_SRAM];
		end
	end

	// Steering is registered so the selects follow the address by one cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			remap_sram_o <= 1'b0;
			low_sram_sel_o <= 1'b0;
			low_nvm_sel_o <= 1'b0;
		end else begin
			remap_sram_o <= remap;
			low_sram_sel_o <= (map_adr_i < `VECTOR_REGION_TOP) & remap;
			low_nvm_sel_o <= (map_adr_i < `VECTOR_REGION_TOP) & ~remap;
		end
	end

	// ****************************************
	// Reset cause record
	// ****************************************
	// A new cause in the same cycle as its clear survives the clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			cause <= `RST_RESET_CAUSE_STATUS;
		end else begin
			cause[`BIT_CAUSE_POWER_ON] <= cause[`BIT_CAUSE_POWER_ON] &
				~(wr & hit_clear & wdat[`BIT_CAUSE_POWER_ON]);
			cause[`BIT_CAUSE_WATCHDOG] <= wdt_timeout_i | (cause[`BIT_CAUSE_WATCHDOG] &
				~(wr & hit_clear & wdat[`BIT_CAUSE_WATCHDOG]));
			cause[`BIT_CAUSE_SOFTWARE] <= sw_req | (cause[`BIT_CAUSE_SOFTWARE] &
				~(wr & hit_clear & wdat[`BIT_CAUSE_SOFTWARE]));
			cause[7:3] <= 5'h00;
		end
	end
	// External resets set no bit, so an all-zero record means external

	// ****************************************
	// Retention key sequence
	// ****************************************
	always @* begin
		next_key_state = key_state;
		if (wr) begin
			case (key_state)
				KEY_IDLE: begin
					if (hit_key_a & (wdat == `KEY_A_CODE)) begin
						next_key_state = KEY_ARMED;
					end
				end
				KEY_ARMED: begin
					if (hit_cfg) begin
						next_key_state = KEY_HELD;
					end else begin
						next_key_state = KEY_IDLE;
					end
				end
				KEY_HELD: begin
					next_key_state = KEY_IDLE;
				end
				default: begin
					next_key_state = KEY_IDLE;
				end
			endcase
		end
	end

	// Any other write between the steps breaks the sequence
	assign key_error = wr & (((key_state == KEY_ARMED) & ~hit_cfg) |
		((key_state == KEY_HELD) & ~(hit_key_b & (wdat == `KEY_B_CODE))));
	assign cfg_commit = wr & (key_state == KEY_HELD) & hit_key_b &
		(wdat == `KEY_B_CODE);

	always @(posedge clk_i) begin
		if (rst_i) begin
			key_state <= KEY_IDLE;
			pending <= `RST_RESET_RETENTION_CONFIG;
			retain <= `RST_RESET_RETENTION_CONFIG;
		end else begin
			key_state <= next_key_state;
			if (wr & hit_cfg & (key_state == KEY_ARMED)) begin
				pending <= wdat & `RETENTION_MASK;
			end
			if (cfg_commit) begin
				retain <= pending;
			end
		end
	end

	// ****************************************
	// Reset sequencer
	// ****************************************
	// Cause, retention, key, event and mask registers survive watchdog and software resets; only rst_i clears them
	always @* begin
		next_seq_state = seq_state;
		next_count = count;
		next_hard = hard;
		if (any_reset) begin
			next_seq_state = SEQ_HOLD;
			next_count = 16'h0000;
			next_hard = ext_low | (hard & (seq_state == SEQ_HOLD));
		end else begin
			case (seq_state)
				SEQ_HOLD: begin
					if (count == HOLD_CYCLES - 16'h0001) begin
						next_seq_state = SEQ_KERNEL;
						next_count = 16'h0000;
					end else begin
						next_count = count + 16'h0001;
					end
				end
				SEQ_KERNEL: begin
					if (count == KERNEL_CYCLES - 16'h0001) begin
						if (boot_high) begin
							next_seq_state = SEQ_RUN;
							next_count = 16'h0000;
						end
					end else begin
						next_count = count + 16'h0001;
					end
				end
				SEQ_RUN: begin
					next_hard = 1'b0;
				end
				default: begin
					next_seq_state = SEQ_HOLD;
					next_count = 16'h0000;
				end
			endcase
		end
	end

	assign boot_done = (seq_state == SEQ_KERNEL) & (next_seq_state == SEQ_RUN);

	always @(posedge clk_i) begin
		if (rst_i) begin
			seq_state <= SEQ_HOLD;
			count <= 16'h0000;
			hard <= 1'b1;
		end else begin
			seq_state <= next_seq_state;
			count <= next_count;
			hard <= next_hard;
		end
	end

	// Outputs track the next state so they change with the state register
	always @(posedge clk_i) begin
		if (rst_i) begin
			sys_rst_o <= 1'b1;
			gpio_rst_o <= 1'b1;
			dac_rst_o <= 1'b1;
			kernel_active_o <= 1'b0;
			user_jump_o <= 1'b0;
			user_vector_o <= `USER_RESET_VECTOR;
		end else begin
			sys_rst_o <= (next_seq_state == SEQ_HOLD);
			gpio_rst_o <= (next_seq_state == SEQ_HOLD) &
				(next_hard | ~retain[`BIT_KEEP_GPIO]);
			dac_rst_o <= (next_seq_state == SEQ_HOLD) &
				(next_hard | ~retain[`BIT_KEEP_DAC]);
			kernel_active_o <= (next_seq_state == SEQ_KERNEL);
			user_jump_o <= boot_done;
			user_vector_o <= `USER_RESET_VECTOR;
		end
	end

	// ****************************************
	// Event flags and interrupt
	// ****************************************
	assign evt_set = {5'h00, boot_done, key_error, cfg_commit};

	// Set wins over a write-one clear in the same cycle
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : evt_bit
			always @(posedge clk_i) begin
				if (rst_i) begin
					evt[i] <= EVT_RESET[i];
				end else if (EVT_USED[i]) begin
					evt[i] <= evt_set[i] | (evt[i] & ~(wr & hit_evt & wdat[i]));
				end else begin
					evt[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge clk_i) begin
		if (rst_i) begin
			mask <= `RST_EVENT_MASK;
			irq_o <= 1'b0;
		end else begin
			if (wr & hit_mask) begin
				mask <= wdat & `EVENT_MASK_BITS;
			end
			irq_o <= |(evt & mask);
		end
	end

endmodule

`default_nettype wire

// >>> bench/reset_remap_checker.sv
// Port assertions for the reset-cause and remap block.
// Assumes binding into its top module; all logic on clk_i.
`default_nettype none
module reset_remap_checker #(
	parameter [15:0] HOLD_CYCLES = 16'h0010,
	parameter [15:0] KERNEL_CYCLES = 16'h0020
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Bus
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	// Reset sources
	input wire ext_rst_n_i,
	input wire wdt_timeout_i,
	// Map
	input wire [31:0] map_adr_i,
	input wire remap_sram_o,
	input wire low_sram_sel_o,
	input wire low_nvm_sel_o,
	// Sequencer
	input wire sys_rst_o,
	input wire gpio_rst_o,
	input wire dac_rst_o,
	input wire kernel_active_o,
	input wire user_jump_o,
	input wire [31:0] user_vector_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
// Kernel phase length; a counter because the figure is a parameter
logic [15:0] kcnt;
always_ff @(posedge clk_i) begin
	if (rst_i || !kernel_active_o)
		kcnt <= 16'h0000;
	else
		kcnt <= kcnt + 16'h0001;
end
sequence s_req;
	cyc_i && stb_i && !ack_o;
endsequence
sequence s_hold_end;
	sys_rst_o ##1 !sys_rst_o;
endsequence
a_ack_next: assert property (s_req |=> ack_o) else $error("ack late");
a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
a_wdt_hold: assert property (wdt_timeout_i |=> sys_rst_o) else $error("no reset");
a_wdt_remap: assert property (wdt_timeout_i |-> ##3 !remap_sram_o)
	else $error("remap kept");
a_ext_hard: assert property (!ext_rst_n_i |-> ##3 (gpio_rst_o && dac_rst_o))
	else $error("soft ext reset");
a_sram_sel: assert property (!$past(rst_i) |->
	low_sram_sel_o == ($past(map_adr_i) < 32'h00000020 && remap_sram_o)) else $error("sram sel");
a_nvm_sel: assert property (!$past(rst_i) |->
	low_nvm_sel_o == ($past(map_adr_i) < 32'h00000020 && !remap_sram_o)) else $error("nvm sel");
a_hold_kernel: assert property (s_hold_end |-> kernel_active_o) else $error("no kernel");
a_jump_vector: assert property (user_jump_o |->
	user_vector_o == 32'h00000000 && kcnt >= KERNEL_CYCLES && !kernel_active_o)
	else $error("bad jump");
endmodule
bind reset_cause_and_memory_remap reset_remap_checker #(
	.HOLD_CYCLES(HOLD_CYCLES),
	.KERNEL_CYCLES(KERNEL_CYCLES)
) reset_remap_checker_i (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .ext_rst_n_i, .wdt_timeout_i,
	.map_adr_i, .remap_sram_o, .low_sram_sel_o, .low_nvm_sel_o, .sys_rst_o, .gpio_rst_o,
	.dac_rst_o, .kernel_active_o, .user_jump_o, .user_vector_o);
`default_nettype wire

// >>> bench/test_reset_cause_and_memory_remap.sv
// Self-checking bench for the reset-cause and remap block.
// Assumes short sequencer counts and a classic Wishbone master.
`default_nettype none
module test_reset_cause_and_memory_remap;
timeunit 1ns;
timeprecision 100ps;
localparam logic [31:0] B = 32'hffff0200;
logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
logic ext_rst_n_i = 1'b1, wdt_timeout_i = 1'b0, boot_mode_pin_i = 1'b1;
logic ack_o, remap_sram_o, low_sram_sel_o, low_nvm_sel_o, sys_rst_o, gpio_rst_o, dac_rst_o;
logic kernel_active_o, user_jump_o, irq_o;
logic [31:0] adr_i = 32'h0, dat_i = 32'h0, map_adr_i = 32'h100, dat_o, user_vector_o, q;
logic [3:0] sel_i = 4'hf;
int num_errors = 0, comparisons = 0, cycles = 0;
typedef struct {logic w; logic [7:0] a; logic [7:0] d;} row_t;
row_t rows [9] = '{
	'{1'b0, 8'h30, 8'h01},
	'{1'b0, 8'h4c, 8'h05},
	'{1'b0, 8'h20, 8'h00},
	'{1'b0, 8'h48, 8'h00},
	'{1'b0, 8'h80, 8'h00},
	'{1'b1, 8'h4c, 8'h00},
	'{1'b0, 8'h4c, 8'h05},
	'{1'b1, 8'h80, 8'hff},
	'{1'b0, 8'h80, 8'h00}};
reset_cause_and_memory_remap #(
	.HOLD_CYCLES(16'h0002),
	.KERNEL_CYCLES(16'h0002)
) reset_cause_and_memory_remap_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
	.dat_i, .ack_o, .dat_o, .ext_rst_n_i, .wdt_timeout_i, .boot_mode_pin_i, .map_adr_i,
	.remap_sram_o, .low_sram_sel_o, .low_nvm_sel_o, .sys_rst_o, .gpio_rst_o, .dac_rst_o,
	.kernel_active_o, .user_jump_o, .user_vector_o, .irq_o);
always #12.5 clk_i = ~clk_i;
// ****
// Tasks
// ****
task test_done();
	$display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
	if (num_errors == 0 && comparisons > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
	comparisons++;
	if (got !== exp) begin
		num_errors++;
		$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
	@(posedge clk_i);
	cyc_i <= 1'b1;
	stb_i <= 1'b1;
	we_i <= w;
	adr_i <= B + {24'h0, a};
	dat_i <= {24'h0, d};
	do
		@(posedge clk_i);
	while (ack_o !== 1'b1);
	q = dat_o;
	cyc_i <= 1'b0;
	stb_i <= 1'b0;
endtask
task rd(input logic [7:0] a, input logic [7:0] d);
	wb(1'b0, a, 8'h00);
	chk(q, {24'h0, d});
endtask
task map(input logic [31:0] a, input logic [1:0] e);
	@(posedge clk_i);
	map_adr_i <= a;
	repeat (2) @(posedge clk_i);
	#1;
	chk({30'h0, low_sram_sel_o, low_nvm_sel_o}, {30'h0, e});
endtask
task run();
	while (user_jump_o !== 1'b1)
		@(posedge clk_i);
endtask
task rsts(input logic [2:0] e);
	#1;
	chk({29'h0, sys_rst_o, gpio_rst_o, dac_rst_o}, {29'h0, e});
endtask
// Hang guard: the whole sequence needs about two hundred cycles
always @(posedge clk_i) begin
	cycles++;
	if (cycles == 3000) begin
		num_errors++;
		test_done();
	end
end
// ****
// Sequence
// ****
initial begin
	repeat (3) @(posedge clk_i);
	rst_i <= 1'b0;
	run();
	foreach (rows[i])
		if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d); else rd(rows[i].a, rows[i].d);
	wb(1'b1, 8'h20, 8'h01);
	map(32'h1c, 2'b10);
	map(32'h20, 2'b00);
	map(32'h00080024, 2'b00);
	wb(1'b1, 8'h20, 8'h00);
	map(32'h00, 2'b01);
	wb(1'b1, 8'h20, 8'h01);
	wb(1'b1, 8'h34, 8'h07);
	rd(8'h30, 8'h00);
	@(posedge clk_i);
	wdt_timeout_i <= 1'b1;
	@(posedge clk_i);
	wdt_timeout_i <= 1'b0;
	rsts(3'b100);
	run();
	rd(8'h30, 8'h02);
	rd(8'h20, 8'h00);
	wb(1'b1, 8'h48, 8'h76);
	wb(1'b1, 8'h4c, 8'h04);
	wb(1'b1, 8'h50, 8'hb1);
	rd(8'h4c, 8'h04);
	wb(1'b1, 8'h48, 8'h76);
	wb(1'b1, 8'h4c, 8'h01);
	wb(1'b1, 8'h20, 8'h00);
	rd(8'h4c, 8'h04);
	chk({31'h0, irq_o}, 32'h0);
	rd(8'h60, 8'h07);
	wb(1'b1, 8'h64, 8'h02);
	@(posedge clk_i);
	#1;
	chk({31'h0, irq_o}, 32'h1);
	wb(1'b1, 8'h60, 8'h02);
	@(posedge clk_i);
	#1;
	chk({31'h0, irq_o}, 32'h0);
	rd(8'h60, 8'h05);
	wb(1'b1, 8'h34, 8'h07);
	wb(1'b1, 8'h30, 8'h04);
	rsts(3'b110);
	run();
	rd(8'h30, 8'h04);
	wb(1'b1, 8'h34, 8'h07);
	@(posedge clk_i);
	ext_rst_n_i <= 1'b0;
	repeat (2) @(posedge clk_i);
	ext_rst_n_i <= 1'b1;
	@(posedge clk_i);
	rsts(3'b111);
	run();
	rd(8'h30, 8'h00);
	// Boot pin low keeps the kernel in control until the pin rises
	@(posedge clk_i);
	boot_mode_pin_i <= 1'b0;
	wdt_timeout_i <= 1'b1;
	@(posedge clk_i);
	wdt_timeout_i <= 1'b0;
	repeat (20) @(posedge clk_i);
	chk({31'h0, kernel_active_o}, 32'h1);
	boot_mode_pin_i <= 1'b1;
	run();
	chk(user_vector_o, 32'h0);
	// Power-on reset in mid-run: cause record back to power-on, remap cleared
	wb(1'b1, 8'h20, 8'h01);
	@(posedge clk_i);
	rst_i <= 1'b1;
	repeat (3) @(posedge clk_i);
	rst_i <= 1'b0;
	rsts(3'b111);
	run();
	rd(8'h30, 8'h01);
	rd(8'h20, 8'h00);
	test_done();
end
endmodule
`default_nettype wire
